// ===== shared/rmid_consts.vh
// register offsets and constants for the raw measurement and id bank
`ifndef RMID_CONSTS_VH
`define RMID_CONSTS_VH
`define RMID_ADDR_W 8
`define RMID_DATA_W 8
`define RMID_MEAS_W 24
`define RMID_CH0_B0 8'h59
`define RMID_CH0_B1 8'h5A
`define RMID_CH0_B2 8'h5B
`define RMID_CH1_B0 8'h5C
`define RMID_CH1_B1 8'h5D
`define RMID_CH1_B2 8'h5E
`define RMID_CH2_B0 8'h5F
`define RMID_CH2_B1 8'h60
`define RMID_CH2_B2 8'h61
`define RMID_CH3_B0 8'h62
`define RMID_CH3_B1 8'h63
`define RMID_CH3_B2 8'h64
`define RMID_MAKER_LO 8'hFC
`define RMID_MAKER_HI 8'hFD
`define RMID_PART_LO 8'hFE
`define RMID_PART_HI 8'hFF
`define RMID_MEAS_RST 24'h000000
`define RMID_BYTE_ZERO 8'h00
`endif

// ===== hdl/rmid_meas_hold.v
// one channel's 24-bit measurement holding register
`include "rmid_consts.vh"
module rmid_meas_hold #(
  parameter WIDTH = `RMID_MEAS_W
) (
  input wire mclk_in, // device clock
  input wire rst_in, // async reset, active high
  input wire ce_in, // clock enable
  input wire load_in, // engine load strobe
  input wire [WIDTH-1:0] value_in, // engine value
  output reg [WIDTH-1:0] value_out // held value
);
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      value_out <= `RMID_MEAS_RST;
    end else if (ce_in && load_in) begin
      value_out <= value_in;
    end
  end
endmodule // rmid_meas_hold

// ===== hdl/rmid_regs.v
// read-only raw measurement and identity register bank
`include "rmid_consts.vh"
// Contract
// - channel 0 bytes at 0x59..0x5B
// - channel 1 bytes at 0x5C..0x5E
// - channel 2 bytes at 0x5F..0x61
// - channel 3 bytes at 0x62..0x64
// - measurement bytes read-only, zero after reset
// - fixed maker code at 0xFC/0xFD
// - fixed part code at 0xFE/0xFF
module rmid_regs #(
  parameter CHANNELS = 4,
  parameter [15:0] MAKER_CODE = 16'hA5C3, // arbitrary value
  parameter [15:0] PART_CODE = 16'h1234 // arbitrary value
) (
  input wire mclk_in, // device clock
  input wire rst_in, // async reset, active high
  input wire ce_in, // clock enable, freezes state when low
  input wire [CHANNELS-1:0] meas_load_in, // per-channel load strobe
  input wire [CHANNELS*`RMID_MEAS_W-1:0] meas_value_in, // packed values
  input wire rd_en_in, // register read strobe
  input wire wr_en_in, // register write strobe
  input wire [`RMID_ADDR_W-1:0] addr_in, // register offset
  input wire [`RMID_DATA_W-1:0] wdata_in, // write data, discarded
  output reg [`RMID_DATA_W-1:0] rdata_out, // read data, registered
  output reg rvalid_out, // read data valid pulse
  output reg wack_out, // write accepted pulse
  output reg hit_out // last access hit a mapped offset
);
  wire [CHANNELS*`RMID_MEAS_W-1:0] held;
  reg [`RMID_DATA_W-1:0] rdata_nxt;
  reg hit_nxt;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
      rmid_meas_hold #(
        .WIDTH(`RMID_MEAS_W)
      ) u_hold (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .load_in(meas_load_in[g]),
        .value_in(meas_value_in[g*`RMID_MEAS_W +: `RMID_MEAS_W]),
        .value_out(held[g*`RMID_MEAS_W +: `RMID_MEAS_W])
      );
    end
  endgenerate

  // byte select within a 24-bit word, lowest byte first
  function [`RMID_DATA_W-1:0] pick_byte;
    input [`RMID_MEAS_W-1:0] word;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: pick_byte = word[7:0];
        2'h1: pick_byte = word[15:8];
        2'h2: pick_byte = word[23:16];
        default: pick_byte = `RMID_BYTE_ZERO;
      endcase
    end
  endfunction

  always @* begin
    rdata_nxt = `RMID_BYTE_ZERO;
    hit_nxt = 1'b1;
    case (addr_in)
      `RMID_CH0_B0: rdata_nxt = pick_byte(held[23:0], 2'h0);
      `RMID_CH0_B1: rdata_nxt = pick_byte(held[23:0], 2'h1);
      `RMID_CH0_B2: rdata_nxt = pick_byte(held[23:0], 2'h2);
      `RMID_CH1_B0: rdata_nxt = pick_byte(held[47:24], 2'h0);
      `RMID_CH1_B1: rdata_nxt = pick_byte(held[47:24], 2'h1);
      `RMID_CH1_B2: rdata_nxt = pick_byte(held[47:24], 2'h2);
      `RMID_CH2_B0: rdata_nxt = pick_byte(held[71:48], 2'h0);
      `RMID_CH2_B1: rdata_nxt = pick_byte(held[71:48], 2'h1);
      `RMID_CH2_B2: rdata_nxt = pick_byte(held[71:48], 2'h2);
      `RMID_CH3_B0: rdata_nxt = pick_byte(held[95:72], 2'h0);
      `RMID_CH3_B1: rdata_nxt = pick_byte(held[95:72], 2'h1);
      `RMID_CH3_B2: rdata_nxt = pick_byte(held[95:72], 2'h2);
      `RMID_MAKER_LO: rdata_nxt = MAKER_CODE[7:0];
      `RMID_MAKER_HI: rdata_nxt = MAKER_CODE[15:8];
      `RMID_PART_LO: rdata_nxt = PART_CODE[7:0];
      `RMID_PART_HI: rdata_nxt = PART_CODE[15:8];
      default: hit_nxt = 1'b0;
    endcase
  end

  // wdata_in never reaches storage: every offset here is read-only
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= `RMID_BYTE_ZERO;
      rvalid_out <= 1'b0;
      wack_out <= 1'b0;
      hit_out <= 1'b0;
    end else if (ce_in) begin
      rvalid_out <= rd_en_in;
      wack_out <= wr_en_in && !rd_en_in;
      if (rd_en_in) begin
        rdata_out <= rdata_nxt;
      end
      if (rd_en_in || wr_en_in) begin
        hit_out <= hit_nxt;
      end
    end
  end
endmodule // rmid_regs

// ===== verification/rmid_regs_sva.sv
// assertion checker for the register bank ports
module rmid_regs_sva #(parameter [15:0] MAKER_CODE = 16'h0,
  parameter [15:0] PART_CODE = 16'h0) (
  input wire logic mclk_in, rst_in, ce_in, rd_en_in, wr_en_in, rvalid_out,
  input wire logic wack_out, hit_out,
  input wire logic [7:0] addr_in, rdata_out,
  input wire logic [3:0] meas_load_in,
  input wire logic [95:0] meas_value_in);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  wire rd = ce_in && rd_en_in;
  sequence s_ld0; ce_in && meas_load_in[0] ##1 !meas_load_in[0]; endsequence
  sequence s_rd0; rd && addr_in == 8'h59 && !meas_load_in[0]; endsequence
  a_rd_pulse: assert property (rd |=> rvalid_out) else $error("rv");
  a_wr_ack: assert property (ce_in && wr_en_in && !rd_en_in |=>
    wack_out && !rvalid_out) else $error("wack");
  a_map_hit: assert property (rd && addr_in inside {[8'h59:8'h64]}
    |=> hit_out) else $error("hit");
  a_maker_lo: assert property (rd && addr_in == 8'hFC
    |=> rdata_out == MAKER_CODE[7:0]) else $error("mk lo");
  a_maker_hi: assert property (rd && addr_in == 8'hFD
    |=> rdata_out == MAKER_CODE[15:8]) else $error("mk hi");
  a_part_lo: assert property (rd && addr_in == 8'hFE
    |=> rdata_out == PART_CODE[7:0]) else $error("pt lo");
  a_part_hi: assert property (rd && addr_in == 8'hFF
    |=> rdata_out == PART_CODE[15:8]) else $error("pt hi");
  a_wr_quiet: assert property (ce_in && wr_en_in && !rd_en_in
    |=> $stable(rdata_out)) else $error("wr data");
  a_load_seen: assert property (s_ld0 ##1 s_rd0
    |=> rdata_out == $past(meas_value_in[7:0], 3)) else $error("load");
endmodule // rmid_regs_sva

// ===== verification/rmid_host.sv
// host side model issuing single register transfers
module rmid_host (
  input wire logic clk_in, // bank clock
  output logic rd_out, // read strobe
  output logic wr_out, // write strobe
  output logic [7:0] addr_out); // offset
  initial begin
    rd_out = 0;
    wr_out = 0;
    addr_out = 8'h00;
  end
  task automatic xfer(input logic w, input logic [7:0] a);
    @(posedge clk_in) #1;
    {rd_out, wr_out, addr_out} = {!w, w, a};
    // released offset is inverted so a stale value never looks valid
    @(posedge clk_in) #1;
    {rd_out, wr_out, addr_out} = {2'b00, ~a};
  endtask
endmodule // rmid_host

// ===== verification/tb_raw_measurement_and_id_regs.sv
// bench for the raw measurement and id register bank
module tb_raw_measurement_and_id_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MK = 16'h5A3C, PT = 16'h2B71; // arbitrary values
  localparam logic [95:0] V = 96'h0C0B0A090807060504030201;
  logic mclk_in = 0, rst_in = 1, ce_in = 1, rd, wr, rv, wk, hit;
  logic [3:0] ld = 4'h0;
  logic [7:0] a, rdata;
  logic [95:0] val = 96'h0;
  int n_errors = 0, tests_run = 0;
  logic [15:0] rows [5] = '{{8'hFC, MK[7:0]}, {8'hFD, MK[15:8]},
    {8'hFE, PT[7:0]}, {8'hFF, PT[15:8]}, 16'h5800};
  always #2 mclk_in = ~mclk_in;
  rmid_host rmid_host_inst (.clk_in(mclk_in), .rd_out(rd), .wr_out(wr),
    .addr_out(a));
  rmid_regs #(.MAKER_CODE(MK), .PART_CODE(PT)) rmid_regs_inst (.mclk_in,
    .rst_in, .ce_in, .meas_load_in(ld), .meas_value_in(val), .rd_en_in(rd),
    .wr_en_in(wr), .addr_in(a), .wdata_in(8'hFF), .rdata_out(rdata),
    .rvalid_out(rv), .wack_out(wk), .hit_out(hit));
  task automatic ck(input bit ok, input logic [7:0] ad);
    tests_run++;
    if (!ok) begin
      n_errors++;
      $display("unexpected %0t at %h got %h", $time, ad, rdata);
    end
  endtask
  task automatic chk(input logic [7:0] ad, e);
    rmid_host_inst.xfer(1'b0, ad);
    ck(rdata === e && rv === 1'b1 && hit === (ad inside {[8'h59:8'h64],
      [8'hFC:8'hFF]}), ad);
  endtask
  task automatic summarize;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk_in);
    #1 rst_in = 0;
    for (int i = 0; i < 12; i++) chk(8'h59 + i, 8'h00);
    val = V;
    ld = 4'hF;
    @(posedge mclk_in) #1 ld = 4'h0;
    for (int i = 0; i < 12; i++) chk(8'h59 + i, V[8*i +: 8]);
    foreach (rows[i]) chk(rows[i][15:8], rows[i][7:0]);
    rmid_host_inst.xfer(1'b1, 8'h5A);
    ck(wk === 1'b1 && rv === 1'b0, 8'h5A);
    chk(8'h5A, V[15:8]);
    rst_in = 1;
    #8 rst_in = 0;
    chk(8'h5B, 8'h00);
    // let the read pulse drop first, since a low enable freezes it
    @(posedge mclk_in) #1;
    ce_in = 0;
    ld = 4'h1;
    val = {96{1'b1}};
    rmid_host_inst.xfer(1'b0, 8'h59);
    ck(rv === 1'b0 && rdata === 8'h00, 8'h59);
    ce_in = 1;
    ld = 4'h0;
    chk(8'h59, 8'h00);
    summarize();
  end
  initial begin
    #4000;
    n_errors++;
    summarize();
  end
endmodule // tb_raw_measurement_and_id_regs
bind rmid_regs rmid_regs_sva #(.MAKER_CODE(MAKER_CODE),
  .PART_CODE(PART_CODE)) rmid_regs_sva_inst (.*);
